// [hw/ais_top.sv]
// Notes on behaviour
// R1: Source codes 0000, 0100, 1100-1111 route the external channel.
// R2: Codes 0001/0010/0011 pick converter supply full, half, quarter.
// R3: Codes 0101/0110/0111 pick amplifier output full, half, quarter.
// R4: Source codes 10xx tie the converter input to ground.
// R5: Internal source disconnects the external path whatever channel says.
// R6: External source: channel codes 3-7 pick a pin, 1100-1111 float.
// R7: Conversion clock is system clock divided by two to the field.
// R8: Bit 3 of the input and clock register reads zero.
// R9: Software enables the amplifier whenever its output is used.
// R10: Amplifier input from reference pin at 0, bandgap at 1.
// R11: Choosing bandgap disconnects the reference pin from the amplifier.
// R12: Software enables the bandgap before choosing it as amplifier input.
// R13: Reference: supply at 00, pin at 01, amplifier output at 1x.
// R14: Internal reference source disconnects the external reference pin.
// R15: Gain field codes 00-11 set gain 1, 1.667, 2.5, 3.333.
// R16: Bandgap register holds enable in bit 0, bits 7-1 read zero.
// R17: Bits 6 and 5 of the reference register read zero.
// R18: Software waits for bandgap start-up before relying on it.
// R19: Analog pin drops other functions and pull-up, overrides direction.
// R20: Reserved channel codes 0-2 and 8-11 select no channel.
// R21: All fields clear on reset and are written on the system clock.
`include "ais_regs.svh"
`default_nettype none

module ais_top
    import ais_pkg::*;
(
    input  wire logic        mclk,
    input  wire logic        sys_rst,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output var  logic [31:0] prdata,
    output var  logic        pready,
    output var  logic        pslverr,
    input  wire logic [4:0]  pin_oe_req,
    input  wire logic [4:0]  pin_pullup_req,
    input  wire logic [4:0]  pin_alt_req,
    output var  logic [4:0]  pin_oe,
    output var  logic [4:0]  pin_pullup_en,
    output var  logic [4:0]  pin_alt_en,
    output var  logic [4:0]  pin_analog_en,
    output var  logic [4:0]  external_analog_channel,
    output var  logic        ext_path_en,
    output var  logic        supply_full_en,
    output var  logic        supply_half_en,
    output var  logic        supply_quarter_en,
    output var  logic        amp_out_full_en,
    output var  logic        amp_out_half_en,
    output var  logic        amp_out_quarter_en,
    output var  logic        ground_en,
    output var  logic        amp_enable,
    output var  logic        amp_ref_input_pin_en,
    output var  logic        amp_bandgap_en,
    output var  logic [1:0]  amp_gain_sel,
    output var  logic        ref_supply_en,
    output var  logic        ref_pin_en,
    output var  logic        ref_amp_en,
    output var  logic        bandgap_enable,
    output var  logic        conv_clk_tick
);

    // ************************************************************
    // Register state
    // ************************************************************
    logic [3:0]  input_source_sel_r;
    logic [2:0]  conv_clock_div_sel_r;
    logic        amp_enable_r;
    logic        amp_input_sel_r;
    logic [1:0]  reference_sel_r;
    logic [1:0]  amp_gain_sel_r;
    logic        bandgap_enable_r;
    logic [3:0]  external_channel_sel_r;
    logic [4:0]  pin_analog_r;

    logic        setup;
    logic        access;
    logic        wr_lane0;
    logic        mapped;
    ais_byte_t   rd_byte;
    ais_byte_t   status;
    logic [31:0] prdata_r;
    logic        pslverr_r;

    ais_src_e    src;
    ais_scale_e  scale;
    ais_ref_e    ref_kind;
    logic [4:0]  chan_onehot;
    logic [3:0]  chan_offset;

    assign setup    = psel && !penable;
    assign access   = psel && penable;
    assign wr_lane0 = access && pwrite && pstrb[0];

    // ************************************************************
    // Register writes
    // ************************************************************
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            input_source_sel_r   <= 4'(`AIS_RST_INCLK >> `AIS_SRC_LSB); // R21
            conv_clock_div_sel_r <= 3'(`AIS_RST_INCLK);
        end else if (wr_lane0 && paddr == `AIS_OFF_INCLK) begin
            input_source_sel_r   <= pwdata[`AIS_SRC_MSB:`AIS_SRC_LSB];
            conv_clock_div_sel_r <= pwdata[`AIS_CKDIV_MSB:`AIS_CKDIV_LSB];
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            amp_enable_r    <= 1'(`AIS_RST_REFGAIN >> `AIS_AMPEN_BIT); // R21
            amp_input_sel_r <= 1'(`AIS_RST_REFGAIN >> `AIS_AMPIN_BIT);
            reference_sel_r <= 2'(`AIS_RST_REFGAIN >> `AIS_REFSEL_LSB);
            amp_gain_sel_r  <= 2'(`AIS_RST_REFGAIN);
        end else if (wr_lane0 && paddr == `AIS_OFF_REFGAIN) begin
            amp_enable_r    <= pwdata[`AIS_AMPEN_BIT];
            amp_input_sel_r <= pwdata[`AIS_AMPIN_BIT];
            reference_sel_r <= pwdata[`AIS_REFSEL_MSB:`AIS_REFSEL_LSB];
            amp_gain_sel_r  <= pwdata[`AIS_GAIN_MSB:`AIS_GAIN_LSB];
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            bandgap_enable_r <= 1'(`AIS_RST_BANDGAP); // R21
        end else if (wr_lane0 && paddr == `AIS_OFF_BANDGAP) begin
            bandgap_enable_r <= pwdata[`AIS_BGEN_BIT]; // R16
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            external_channel_sel_r <= 4'(`AIS_RST_EXTCH); // R21
        end else if (wr_lane0 && paddr == `AIS_OFF_EXTCH) begin
            external_channel_sel_r <= pwdata[`AIS_EXTCH_MSB:`AIS_EXTCH_LSB];
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            pin_analog_r <= 5'(`AIS_RST_PINCFG); // R21
        end else if (wr_lane0 && paddr == `AIS_OFF_PINCFG) begin
            pin_analog_r <= pwdata[`AIS_PINCFG_MSB:`AIS_PINCFG_LSB];
        end
    end

    // ************************************************************
    // Read mux, unused bits read zero
    // ************************************************************
    always_comb begin
        rd_byte = 8'h00;
        mapped  = 1'b1;
        case (paddr)
            `AIS_OFF_INCLK: begin
                rd_byte = {input_source_sel_r, 1'b0,
                           conv_clock_div_sel_r}; // R8
            end
            `AIS_OFF_REFGAIN: begin
                rd_byte = {amp_enable_r, 2'b00, amp_input_sel_r,
                           reference_sel_r, amp_gain_sel_r}; // R17
            end
            `AIS_OFF_BANDGAP: begin
                rd_byte = {7'h00, bandgap_enable_r}; // R16
            end
            `AIS_OFF_EXTCH: begin
                rd_byte = {4'h0, external_channel_sel_r};
            end
            `AIS_OFF_PINCFG: begin
                rd_byte = {3'h0, pin_analog_r};
            end
            `AIS_OFF_STATUS: begin
                rd_byte = status;
            end
            default: begin
                mapped = 1'b0;
            end
        endcase
    end

    // Read data and error latched in setup, held through access
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            prdata_r <= 32'h0000_0000;
        end else if (setup && !pwrite) begin
            prdata_r <= {24'h00_0000, rd_byte};
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            pslverr_r <= 1'b0;
        end else if (setup) begin
            pslverr_r <= !mapped;
        end
    end

    assign prdata  = prdata_r;
    assign pready  = 1'b1;
    assign pslverr = access && pslverr_r;

    // ************************************************************
    // Converter input source decode
    // ************************************************************
    always_comb begin
        src   = AIS_SRC_EXT;
        scale = AIS_SCALE_FULL;
        case (input_source_sel_r)
            4'h0, 4'h4, 4'hc, 4'hd, 4'he, 4'hf: begin
                src = AIS_SRC_EXT; // R1
            end
            4'h1: begin
                src = AIS_SRC_SUPPLY; // R2
            end
            4'h2: begin
                src   = AIS_SRC_SUPPLY; // R2
                scale = AIS_SCALE_HALF;
            end
            4'h3: begin
                src   = AIS_SRC_SUPPLY; // R2
                scale = AIS_SCALE_QUARTER;
            end
            4'h5: begin
                src = AIS_SRC_AMP; // R3
            end
            4'h6: begin
                src   = AIS_SRC_AMP; // R3
                scale = AIS_SCALE_HALF;
            end
            4'h7: begin
                src   = AIS_SRC_AMP; // R3
                scale = AIS_SCALE_QUARTER;
            end
            4'h8, 4'h9, 4'ha, 4'hb: begin
                src = AIS_SRC_GND; // R4
            end
            default: begin
                src = AIS_SRC_EXT;
            end
        endcase
    end

    // Channel pick only with an external source
    assign chan_offset = external_channel_sel_r - `AIS_FIRST_CH;

    always_comb begin
        chan_onehot = 5'h00;
        if (src == AIS_SRC_EXT && // R5
            external_channel_sel_r >= `AIS_FIRST_CH &&
            external_channel_sel_r <= `AIS_LAST_CH) begin // R6 R20
            chan_onehot = 5'(5'h01 << chan_offset);
        end
    end

    // ************************************************************
    // Reference source decode
    // ************************************************************
    always_comb begin
        case (reference_sel_r)
            2'b00: begin
                ref_kind = AIS_REF_SUPPLY; // R13
            end
            2'b01: begin
                ref_kind = AIS_REF_PIN; // R13
            end
            default: begin
                ref_kind = AIS_REF_AMP; // R13
            end
        endcase
    end

    assign status = {1'b0, bandgap_enable_r, ref_kind,
                     (|chan_onehot), 1'b0, src};

    // ************************************************************
    // Analog switch controls
    // ************************************************************
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            external_analog_channel <= 5'h00;
            ext_path_en             <= 1'b0;
        end else begin
            external_analog_channel <= chan_onehot; // R6
            ext_path_en             <= (src == AIS_SRC_EXT); // R5
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            supply_full_en    <= 1'b0;
            supply_half_en    <= 1'b0;
            supply_quarter_en <= 1'b0;
        end else begin
            supply_full_en    <= (src == AIS_SRC_SUPPLY) &&
                                 (scale == AIS_SCALE_FULL); // R2
            supply_half_en    <= (src == AIS_SRC_SUPPLY) &&
                                 (scale == AIS_SCALE_HALF);
            supply_quarter_en <= (src == AIS_SRC_SUPPLY) &&
                                 (scale == AIS_SCALE_QUARTER);
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            amp_out_full_en    <= 1'b0;
            amp_out_half_en    <= 1'b0;
            amp_out_quarter_en <= 1'b0;
            ground_en          <= 1'b0;
        end else begin
            amp_out_full_en    <= (src == AIS_SRC_AMP) &&
                                  (scale == AIS_SCALE_FULL); // R3
            amp_out_half_en    <= (src == AIS_SRC_AMP) &&
                                  (scale == AIS_SCALE_HALF);
            amp_out_quarter_en <= (src == AIS_SRC_AMP) &&
                                  (scale == AIS_SCALE_QUARTER);
            ground_en          <= (src == AIS_SRC_GND); // R4
        end
    end

    // Amplifier powered only by software's enable bit
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            amp_enable           <= 1'b0;
            amp_ref_input_pin_en <= 1'b0;
            amp_bandgap_en       <= 1'b0;
            amp_gain_sel         <= 2'b00;
        end else begin
            amp_enable           <= amp_enable_r;
            amp_ref_input_pin_en <= !amp_input_sel_r; // R10 R11
            amp_bandgap_en       <= amp_input_sel_r; // R10
            amp_gain_sel         <= amp_gain_sel_r; // R15
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            ref_supply_en  <= 1'b0;
            ref_pin_en     <= 1'b0;
            ref_amp_en     <= 1'b0;
            bandgap_enable <= 1'b0;
        end else begin
            ref_supply_en  <= (ref_kind == AIS_REF_SUPPLY); // R13
            ref_pin_en     <= (ref_kind == AIS_REF_PIN); // R14
            ref_amp_en     <= (ref_kind == AIS_REF_AMP); // R13
            bandgap_enable <= bandgap_enable_r; // R16
        end
    end

    // ************************************************************
    // Pin sharing overrides
    // ************************************************************
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            pin_oe        <= 5'h00;
            pin_pullup_en <= 5'h00;
            pin_alt_en    <= 5'h00;
            pin_analog_en <= 5'h00;
        end else begin
            pin_oe        <= pin_oe_req & ~pin_analog_r; // R19
            pin_pullup_en <= pin_pullup_req & ~pin_analog_r; // R19
            pin_alt_en    <= pin_alt_req & ~pin_analog_r; // R19
            pin_analog_en <= pin_analog_r;
        end
    end

    // ************************************************************
    // Conversion clock
    // ************************************************************
    ais_clk_div u_clk_div (
        .mclk    (mclk),
        .sys_rst (sys_rst),
        .div_sel (conv_clock_div_sel_r),
        .tick    (conv_clk_tick)
    );

endmodule

`default_nettype wire

// [common/ais_regs.svh]
`ifndef AIS_REGS_SVH
`define AIS_REGS_SVH

// ****************************************************************
// Register byte offsets
// ****************************************************************
`define AIS_OFF_INCLK    12'h000
`define AIS_OFF_REFGAIN  12'h004
`define AIS_OFF_BANDGAP  12'h008
`define AIS_OFF_EXTCH    12'h00c
`define AIS_OFF_PINCFG   12'h010
`define AIS_OFF_STATUS   12'h014

// ****************************************************************
// Field positions
// ****************************************************************
`define AIS_SRC_MSB      7
`define AIS_SRC_LSB      4
`define AIS_CKDIV_MSB    2
`define AIS_CKDIV_LSB    0
`define AIS_AMPEN_BIT    7
`define AIS_AMPIN_BIT    4
`define AIS_REFSEL_MSB   3
`define AIS_REFSEL_LSB   2
`define AIS_GAIN_MSB     1
`define AIS_GAIN_LSB     0
`define AIS_BGEN_BIT     0
`define AIS_EXTCH_MSB    3
`define AIS_EXTCH_LSB    0
`define AIS_PINCFG_MSB   4
`define AIS_PINCFG_LSB   0

// ****************************************************************
// Reset values and channel range
// ****************************************************************
`define AIS_RST_INCLK    8'h00
`define AIS_RST_REFGAIN  8'h00
`define AIS_RST_BANDGAP  8'h00
`define AIS_RST_EXTCH    8'h00
`define AIS_RST_PINCFG   8'h00
`define AIS_FIRST_CH     4'h3
`define AIS_LAST_CH      4'h7

`endif

// [common/ais_pkg.sv]
`default_nettype none

package ais_pkg;

    typedef enum logic [1:0] {
        AIS_SRC_EXT,
        AIS_SRC_SUPPLY,
        AIS_SRC_AMP,
        AIS_SRC_GND
    } ais_src_e;

    typedef enum logic [1:0] {
        AIS_SCALE_FULL,
        AIS_SCALE_HALF,
        AIS_SCALE_QUARTER
    } ais_scale_e;

    typedef enum logic [1:0] {
        AIS_REF_SUPPLY,
        AIS_REF_PIN,
        AIS_REF_AMP
    } ais_ref_e;

    typedef logic [7:0] ais_byte_t;

endpackage

`default_nettype wire

// [hw/ais_clk_div.sv]
`default_nettype none

module ais_clk_div
    import ais_pkg::*;
(
    input  wire logic       mclk,
    input  wire logic       sys_rst,
    input  wire logic [2:0] div_sel,
    output var  logic       tick
);

    logic [6:0] count_r;
    logic [2:0] sel_r;
    logic [6:0] limit;
    logic       wrap;
    logic       tick_r;

    assign limit = 7'((8'h01 << div_sel) - 8'h01);
    assign wrap  = (count_r >= limit);

    // ************************************************************
    // Divide by two to the power of the select field
    // ************************************************************
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            sel_r <= 3'h0;
        end else begin
            sel_r <= div_sel;
        end
    end

    // Restart the period when the ratio changes
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            count_r <= 7'h00;
        end else if ((sel_r != div_sel) || wrap) begin
            count_r <= 7'h00;
        end else begin
            count_r <= count_r + 7'h01;
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            tick_r <= 1'b0;
        end else begin
            tick_r <= wrap && (sel_r == div_sel); // R7
        end
    end

    assign tick = tick_r;

endmodule

`default_nettype wire

// [tb/ais_top_monitor.sv]
`default_nettype none

module ais_top_monitor
    import ais_pkg::*;
(
    input wire logic        mclk,
    input wire logic        sys_rst,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0]  pstrb,
    input wire logic [4:0]  pin_oe_req,
    input wire logic [4:0]  pin_oe,
    input wire logic [4:0]  pin_analog_en,
    input wire logic [4:0]  external_analog_channel,
    input wire logic [7:0]  src_v,
    input wire logic        ref_supply_en,
    input wire logic        ref_pin_en,
    input wire logic        ref_amp_en,
    input wire logic        amp_ref_input_pin_en,
    input wire logic        amp_bandgap_en,
    input wire logic [1:0]  amp_gain_sel,
    input wire logic        bandgap_enable
);
    timeunit 1ns;
    timeprecision 1ps;

    wire logic wr_go;
    assign wr_go = psel && penable && pwrite && pstrb[0];

    default clocking cb @(posedge mclk); endclocking
    default disable iff (sys_rst);

    // ****************************************************************
    // Assertions
    // ****************************************************************
    chk_src_onehot:
    assert property (!$past(sys_rst) |-> $onehot(src_v))
        else $error("source switches not one-hot");
    chk_ext_gate:
    assert property (external_analog_channel != 5'h00 |->
        src_v[7] && $onehot(external_analog_channel))
        else $error("channel connected without external path");
    chk_ref_onehot:
    assert property (!$past(sys_rst) |->
        $onehot({ref_supply_en, ref_pin_en, ref_amp_en}))
        else $error("reference switches not one-hot");
    chk_amp_input:
    assert property (!$past(sys_rst) |->
        amp_ref_input_pin_en != amp_bandgap_en)
        else $error("amplifier input switches clash");
    chk_pin_override:
    assert property (!$past(sys_rst) |->
        pin_oe == ($past(pin_oe_req) & ~pin_analog_en))
        else $error("analog pin keeps output enable");
    chk_reset_clear:
    assert property ($fell(sys_rst) |=> src_v[7] && ref_supply_en &&
        amp_ref_input_pin_en && !bandgap_enable && amp_gain_sel == 2'h0)
        else $error("fields not cleared by reset");
    chk_gain_write:
    assert property (wr_go && paddr == 12'h004 |=> ##1
        amp_gain_sel == $past(pwdata[1:0], 2))
        else $error("gain output does not follow write");
    chk_ground_write:
    assert property (wr_go && paddr == 12'h000 && pwdata[7:6] == 2'h2
        |-> ##2 src_v[0])
        else $error("ground not selected");
    chk_bandgap_write:
    assert property (wr_go && paddr == 12'h008 |-> ##2
        bandgap_enable == $past(pwdata[0], 2))
        else $error("bandgap enable does not follow write");

    cov_ground: cover property (src_v[0]);
    cov_amp_ref: cover property (ref_amp_en && amp_bandgap_en);
    cov_pin: cover property (pin_analog_en != 5'h00 && pin_oe_req != 5'h00);
endmodule

`default_nettype wire

// [tb/testbench.sv]
`default_nettype none

module testbench;
    timeunit 1ns;
    timeprecision 1ps;

    logic        mclk;
    logic        sys_rst;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic [3:0]  pstrb;
    logic [3:0]  strb;
    logic [4:0]  pin_oe_req;
    logic [4:0]  pin_pullup_req;
    logic [4:0]  pin_alt_req;
    wire  [31:0] prdata;
    wire         pready;
    wire         pslverr;
    wire  [4:0]  pin_oe;
    wire  [4:0]  pin_pullup_en;
    wire  [4:0]  pin_alt_en;
    wire  [4:0]  pin_analog_en;
    wire  [4:0]  ext_ch;
    wire  [7:0]  src_v;
    wire  [2:0]  ref_v;
    wire  [1:0]  amp_v;
    wire  [1:0]  amp_gain_sel;
    wire         amp_enable;
    wire         bandgap_enable;
    wire         conv_clk_tick;
    logic [31:0] seed = 32'h9e48;
    int          error_cnt = 0;
    int          n_compared = 0;

    ais_top DUT (
        .mclk(mclk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .pin_oe_req(pin_oe_req), .pin_pullup_req(pin_pullup_req),
        .pin_alt_req(pin_alt_req), .pin_oe(pin_oe),
        .pin_pullup_en(pin_pullup_en), .pin_alt_en(pin_alt_en),
        .pin_analog_en(pin_analog_en), .external_analog_channel(ext_ch),
        .ext_path_en(src_v[7]), .supply_full_en(src_v[6]),
        .supply_half_en(src_v[5]), .supply_quarter_en(src_v[4]),
        .amp_out_full_en(src_v[3]), .amp_out_half_en(src_v[2]),
        .amp_out_quarter_en(src_v[1]), .ground_en(src_v[0]),
        .amp_enable(amp_enable), .amp_ref_input_pin_en(amp_v[1]),
        .amp_bandgap_en(amp_v[0]), .amp_gain_sel(amp_gain_sel),
        .ref_supply_en(ref_v[2]), .ref_pin_en(ref_v[1]),
        .ref_amp_en(ref_v[0]), .bandgap_enable(bandgap_enable),
        .conv_clk_tick(conv_clk_tick)
    );

    // ****************************************************************
    // Helpers
    // ****************************************************************
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    function automatic logic [7:0] exp_src(input logic [3:0] s);
        case (s)
            4'h1: return 8'h40;
            4'h2: return 8'h20;
            4'h3: return 8'h10;
            4'h5: return 8'h08;
            4'h6: return 8'h04;
            4'h7: return 8'h02;
            4'h8, 4'h9, 4'ha, 4'hb: return 8'h01;
            default: return 8'h80;
        endcase
    endfunction

    function automatic logic [4:0] exp_ch(input logic [3:0] s,
                                          input logic [3:0] c);
        if (exp_src(s) != 8'h80 || c < 4'h3 || c > 4'h7) return 5'h00;
        return 5'h01 << (c - 4'h3);
    endfunction

    task automatic check(input string what, input logic [31:0] got,
                         input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic stop_test();
        $display("compared %0d mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic apb(input logic wr, input logic [11:0] a,
                       input logic [31:0] d, output logic [31:0] rd,
                       output logic err);
        int n;
        @(posedge mclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        pstrb <= wr ? strb : 4'h0;
        @(posedge mclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge mclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) begin
            error_cnt++;
            stop_test();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    initial begin
        mclk = 1'b0;
        forever #20 mclk = ~mclk;
    end

    // ****************************************************************
    // Main sequence
    // ****************************************************************
    initial begin
        logic [31:0] rd;
        logic [31:0] d;
        logic        err;
        logic [3:0]  s;
        logic [3:0]  c;
        int          cnt;
        sys_rst = 1'b1;
        {psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
        strb = 4'h1;
        {pin_oe_req, pin_pullup_req, pin_alt_req} = '0;
        repeat (3) @(posedge mclk);
        sys_rst <= 1'b0;
        for (int a = 0; a < 6; a++) begin
            apb(1'b0, 12'(a * 4), 32'h0, rd, err);
            check("reset value", rd, 32'h0);
        end
        for (int i = 0; i < 32; i++) begin
            d = rnd();
            s = d[9] ? {2'h3, d[11:10]} : {1'b0, d[10], 2'h0};
            s = (i < 16) ? 4'(i) : s;
            c = (i < 16) ? d[15:12] : 4'(i - 16);
            apb(1'b1, 12'h00c, {28'h0, c}, rd, err);
            apb(1'b1, 12'h000, {24'h0, s, d[3:0]}, rd, err);
            apb(1'b0, 12'h000, 32'h0, rd, err);
            check("input clock reg", rd, {24'h0, s, 1'b0, d[2:0]});
            check("source", 32'(src_v), 32'(exp_src(s)));
            check("channel", 32'(ext_ch), 32'(exp_ch(s, c)));
        end
        apb(1'b1, 12'h008, 32'hffff_ffff, rd, err);
        apb(1'b0, 12'h008, 32'h0, rd, err);
        check("bandgap reg", rd, 32'h1);
        check("bandgap out", 32'(bandgap_enable), 32'h1);
        strb = 4'h0;
        apb(1'b1, 12'h008, 32'h0, rd, err);
        strb = 4'h1;
        apb(1'b0, 12'h008, 32'h0, rd, err);
        check("masked write", rd, 32'h1);
        repeat (50) @(posedge mclk);
        for (int i = 0; i < 32; i++) begin
            d = rnd();
            d[7:0] = {d[7] | i[3], d[6:5], i[4:0]};
            apb(1'b1, 12'h004, {24'h0, d[7:0]}, rd, err);
            apb(1'b0, 12'h004, 32'h0, rd, err);
            check("ref gain reg", rd, {24'h0, d[7:0] & 8'h9f});
            check("ref", 32'(ref_v), d[3] ? 32'h1 : 32'h4 >> d[2]);
            check("amp input", 32'(amp_v), {30'h0, ~d[4], d[4]});
            check("gain", 32'(amp_gain_sel), 32'(d[1:0]));
            check("amp enable", 32'(amp_enable), 32'(d[7]));
        end
        apb(1'b1, 12'h018, 32'hff, rd, err);
        check("unmapped write", 32'(err), 32'h1);
        apb(1'b0, 12'h018, 32'h0, rd, err);
        check("unmapped read", {rd[30:0], err}, 32'h1);
        for (int i = 0; i < 16; i++) begin
            d = rnd();
            apb(1'b1, 12'h010, {27'h0, d[4:0]}, rd, err);
            pin_oe_req <= d[9:5];
            pin_pullup_req <= d[14:10];
            pin_alt_req <= d[19:15];
            repeat (3) @(negedge mclk);
            check("analog pins", 32'(pin_analog_en), 32'(d[4:0]));
            check("pin oe", 32'(pin_oe), 32'(d[9:5] & ~d[4:0]));
            check("pull", 32'(pin_pullup_en), 32'(d[14:10] & ~d[4:0]));
            check("alt", 32'(pin_alt_en), 32'(d[19:15] & ~d[4:0]));
        end
        for (int k = 0; k < 8; k++) begin
            apb(1'b1, 12'h000, 32'(k), rd, err);
            repeat (200) @(negedge mclk);
            cnt = 0;
            repeat (256) begin
                @(negedge mclk);
                if (conv_clk_tick === 1'b1) cnt++;
            end
            check("tick count", 32'(cnt), 32'(256 >> k));
        end
        stop_test();
    end
endmodule

bind ais_top ais_top_monitor u_mon (
    .mclk(mclk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .pin_oe_req(pin_oe_req), .pin_oe(pin_oe),
    .pin_analog_en(pin_analog_en),
    .external_analog_channel(external_analog_channel),
    .src_v({ext_path_en, supply_full_en, supply_half_en,
            supply_quarter_en, amp_out_full_en, amp_out_half_en,
            amp_out_quarter_en, ground_en}),
    .ref_supply_en(ref_supply_en), .ref_pin_en(ref_pin_en),
    .ref_amp_en(ref_amp_en), .amp_ref_input_pin_en(amp_ref_input_pin_en),
    .amp_bandgap_en(amp_bandgap_en), .amp_gain_sel(amp_gain_sel),
    .bandgap_enable(bandgap_enable)
);

`default_nettype wire
